// file: verilog/vic_regfile.sv
// vectored interrupt controller register file and core line logic
//
// Operation
// RULE_01: handler address words 0x080..0x0FC, read/write
// RULE_02: normal vector read returns current handler
// RULE_03: normal vector indexed by current source 1..31
// RULE_04: normal vector reads zero when none current
// RULE_05: fast vector read returns source 0 handler
// RULE_06: current source number readable, low field
// RULE_07: pending view, one bit per source
// RULE_08: fixed bit map for all source registers
// RULE_09: enabled view, resets to zero
// RULE_10: core status bit 0 mirrors fast line
// RULE_11: core status bit 1 mirrors normal line
// RULE_12: enable command sets written mask bits
// RULE_13: disable command clears written mask bits
// RULE_14: clear command clears written pending bits
// RULE_15: vector read takes, deasserts, autoclears, pushes
// RULE_16: end of interrupt pops, may reassert line
// RULE_17: priorities 0..7, source 0 has none
// RULE_18: fast vector read clears edge source 0
// RULE_19: normal line when pending outranks current level
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module vic_regfile #(
    parameter int N     = 32,
    parameter int DEPTH = 8
) (
    input  wire logic        ref_clk,     // 25 MHz system clock
    input  wire logic        rst,         // sync reset, high
    input  wire logic [11:0] regAddr,     // byte address
    input  wire logic [31:0] regWrData,   // write data
    input  wire logic        regWr,       // write strobe
    input  wire logic        regRd,       // read strobe
    output logic      [31:0] regRdData,   // read data, next cycle
    input  wire logic [N-1:0] srcIn,      // interrupt sources
    output logic             fastLineN,   // fast request to core, low
    output logic             normalLineN, // normal request to core, low
    output logic             sysIntr      // event interrupt, high
);
    // ----------
    // storage
    // ----------
    logic [31:0]                 vecTab_r [N];
    vic_pkg::vic_mode_t          mode_r   [N];
    logic [N-1:0]                enabled_r;
    logic [N-1:0]                pendEdge_r;
    logic [vic_pkg::PRI_W-1:0]   stkLvl_r [DEPTH];
    logic [vic_pkg::ID_W-1:0]    stkId_r  [DEPTH];
    logic [3:0]                  depth_r;
    logic [vic_pkg::ID_W-1:0]    curId_r;
    logic                        fastLineN_r;
    logic                        normalLineN_r;
    logic [31:0]                 regRdData_r;
    logic [vic_pkg::EVT_W-1:0]   evtStat_r;
    logic [vic_pkg::EVT_W-1:0]   evtMask_r;
    logic                        sysIntr_r;

    // ----------
    // decode
    // ----------
    function automatic logic [vic_pkg::ID_W-1:0] wordIdx(input logic [11:0] a);
        wordIdx = a[6:2];
    endfunction

    logic                        modeSel;
    logic                        vecSel;
    logic                        rdNorm;
    logic                        rdFast;
    logic                        wrEn;
    logic                        wrDis;
    logic                        wrClr;
    logic                        wrEoi;

    always_comb begin
        modeSel = regAddr < vic_pkg::OFF_VEC_BASE;
        vecSel  = regAddr >= vic_pkg::OFF_VEC_BASE && regAddr < vic_pkg::OFF_NORM_VEC;
        rdNorm  = regRd && regAddr == vic_pkg::OFF_NORM_VEC;
        rdFast  = regRd && regAddr == vic_pkg::OFF_FAST_VEC;
        wrEn    = regWr && regAddr == vic_pkg::OFF_EN_CMD;
        wrDis   = regWr && regAddr == vic_pkg::OFF_DIS_CMD;
        wrClr   = regWr && regAddr == vic_pkg::OFF_CLR_CMD;
        wrEoi   = regWr && regAddr == vic_pkg::OFF_EOI_CMD;
    end

    // ----------
    // source conditioning and pending state
    // ----------
    logic [N-1:0] invert;
    logic [N-1:0] edgeMask;
    logic [N-1:0] actv;
    logic [N-1:0] rise;
    logic [N-1:0] pending;
    logic [N-1:0] autoClr;
    logic [N-1:0] pendEdge_nxt;
    logic [vic_pkg::PRI_W-1:0] prio [N];

    // external sources honour polarity; internal ones are active high
    always_comb begin
        for (int i = 0; i < N; i++) begin
            invert[i]   = vic_pkg::EXT_SRC[i] & ~mode_r[i].pol;
            edgeMask[i] = mode_r[i].edgeTrig;
            prio[i]     = mode_r[i].pri;                               // [RULE_17]
        end
    end

    vic_src_cond #(
        .N        (N),
        .EXT_MASK (vic_pkg::EXT_SRC)
    ) u_cond (
        .ref_clk (ref_clk),
        .rst     (rst),
        .srcRaw  (srcIn),
        .invert  (invert),
        .actv    (actv),
        .rise    (rise)
    );

    // level sources follow the line, edge sources latch
    always_comb begin
        pending = vic_pkg::IMPL_SRC[N-1:0]
                & ((edgeMask & pendEdge_r) | (~edgeMask & actv));      // [RULE_07] [RULE_08]
    end

    // ----------
    // priority resolution and stack
    // ----------
    vic_pkg::vic_pick_t        best;
    logic [vic_pkg::PRI_W-1:0] curLvl;
    logic                      stkEmpty;
    logic                      normReq;
    logic                      take;
    logic                      pop;
    logic                      fastReq;

    vic_pick #(
        .N (N)
    ) u_pick (
        .cand (pending & enabled_r),
        .prio (prio),
        .best (best)
    );

    // request when a pending source outranks the current level
    always_comb begin
        stkEmpty = depth_r == 4'h0;
        curLvl   = stkEmpty ? '0 : stkLvl_r[3'(depth_r - 4'h1)];
        normReq  = best.valid && (stkEmpty || best.pri > curLvl);     // [RULE_19] [RULE_16]
        take     = rdNorm && normReq && depth_r < 4'(DEPTH);           // [RULE_15]
        pop      = wrEoi && !stkEmpty;                                 // [RULE_16]
        fastReq  = pending[0] && enabled_r[0];
    end

    // edge sources cleared on take or fast vector read
    always_comb begin
        autoClr = '0;
        if (take && edgeMask[best.id]) begin
            autoClr[best.id] = 1'b1;                                   // [RULE_15]
        end
        if (rdFast && edgeMask[0]) begin
            autoClr[0] = 1'b1;                                         // [RULE_18]
        end
        // a new edge in the clearing cycle is kept
        pendEdge_nxt = (pendEdge_r & ~autoClr
                     & ~(wrClr ? regWrData[N-1:0] : '0))               // [RULE_14]
                     | (rise & edgeMask);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pendEdge_r <= '0;
        end else begin
            pendEdge_r <= pendEdge_nxt;
        end
    end

    // level stack with source ids so the previous context returns
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            depth_r <= 4'h0;
            curId_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                stkLvl_r[i] <= '0;
                stkId_r[i]  <= '0;
            end
        end else if (take) begin
            stkLvl_r[3'(depth_r)] <= best.pri;                         // [RULE_15]
            stkId_r[3'(depth_r)]  <= best.id;
            depth_r               <= depth_r + 4'h1;
            curId_r               <= best.id;
        end else if (pop) begin
            depth_r <= depth_r - 4'h1;                                 // [RULE_16]
            curId_r <= (depth_r == 4'h1) ? '0 : stkId_r[3'(depth_r - 4'h2)];
        end
    end

    // ----------
    // configuration registers
    // ----------
    // handler address table
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                vecTab_r[i] <= vic_pkg::RST_WORD;
            end
        end else if (regWr && vecSel) begin
            vecTab_r[wordIdx(regAddr)] <= regWrData;                   // [RULE_01]
        end
    end

    // source mode: priority, trigger type, polarity
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                mode_r[i] <= '0;
            end
        end else if (regWr && modeSel) begin
            mode_r[wordIdx(regAddr)] <= '{
                pol:      regWrData[vic_pkg::MODE_POL_BIT],
                edgeTrig: regWrData[vic_pkg::MODE_EDGE_BIT],
                pri:      regWrData[vic_pkg::MODE_PRI_LSB +: vic_pkg::PRI_W]
            };
        end
    end

    // enable mask, set and clear by command
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enabled_r <= '0;                                           // [RULE_09]
        end else begin
            enabled_r <= (enabled_r
                       | (wrEn ? regWrData[N-1:0] & vic_pkg::IMPL_SRC[N-1:0] : '0))  // [RULE_12]
                       & ~(wrDis ? regWrData[N-1:0] : '0);             // [RULE_13]
        end
    end

    // ----------
    // core lines
    // ----------
    // take and pop shift the level, so the line follows next cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fastLineN_r   <= 1'b1;
            normalLineN_r <= 1'b1;
        end else begin
            fastLineN_r   <= !fastReq;                                 // [RULE_18]
            normalLineN_r <= !normReq || take;                         // [RULE_15]
        end
    end

    // ----------
    // event status and interrupt
    // ----------
    logic [vic_pkg::EVT_W-1:0] evt;
    logic                      mapped;

    always_comb begin
        evt                        = '0;
        evt[vic_pkg::EV_FAST]      = fastReq && fastLineN_r;
        evt[vic_pkg::EV_NORM]      = normReq && !take && normalLineN_r;
        evt[vic_pkg::EV_BAD_ADDR]  = (regRd || regWr) && !mapped;
        evt[vic_pkg::EV_EOI_EMPTY] = wrEoi && stkEmpty;
    end

    // sticky flags, write one clears, a new event wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evtStat_r <= '0;
            evtMask_r <= '0;
            sysIntr_r <= 1'b0;
        end else begin
            evtStat_r <= (evtStat_r & ~((regWr && regAddr == vic_pkg::OFF_EVT_STAT)
                       ? regWrData[vic_pkg::EVT_W-1:0] : '0)) | evt;
            if (regWr && regAddr == vic_pkg::OFF_EVT_MASK) begin
                evtMask_r <= regWrData[vic_pkg::EVT_W-1:0];
            end
            sysIntr_r <= |(evtStat_r & evtMask_r);
        end
    end

    // ----------
    // read path
    // ----------
    logic [31:0] rdMux;

    always_comb begin
        rdMux  = '0;
        mapped = 1'b1;
        if (modeSel) begin
            rdMux[vic_pkg::MODE_POL_BIT]  = mode_r[wordIdx(regAddr)].pol;
            rdMux[vic_pkg::MODE_EDGE_BIT] = mode_r[wordIdx(regAddr)].edgeTrig;
            rdMux[vic_pkg::MODE_PRI_LSB +: vic_pkg::PRI_W] = mode_r[wordIdx(regAddr)].pri;
        end else if (vecSel) begin
            rdMux = vecTab_r[wordIdx(regAddr)];                        // [RULE_01]
        end else begin
            unique case (regAddr)
                vic_pkg::OFF_NORM_VEC: begin
                    if (take) begin
                        rdMux = vecTab_r[best.id];                     // [RULE_02] [RULE_03]
                    end else if (!stkEmpty) begin
                        rdMux = vecTab_r[curId_r];                     // [RULE_03]
                    end else begin
                        rdMux = '0;                                    // [RULE_04]
                    end
                end
                vic_pkg::OFF_FAST_VEC: rdMux = vecTab_r[0];            // [RULE_05]
                vic_pkg::OFF_CUR_ID:   rdMux[vic_pkg::ID_W-1:0] = curId_r;  // [RULE_06]
                vic_pkg::OFF_PEND:     rdMux[N-1:0] = pending;         // [RULE_07]
                vic_pkg::OFF_ENABLED:  rdMux[N-1:0] = enabled_r;       // [RULE_09]
                vic_pkg::OFF_CORE: begin
                    rdMux[vic_pkg::CORE_FAST_BIT] = !fastLineN_r;      // [RULE_10]
                    rdMux[vic_pkg::CORE_NORM_BIT] = !normalLineN_r;    // [RULE_11]
                end
                vic_pkg::OFF_EN_CMD, vic_pkg::OFF_DIS_CMD,
                vic_pkg::OFF_CLR_CMD, vic_pkg::OFF_EOI_CMD: rdMux = '0;
                vic_pkg::OFF_EVT_STAT: rdMux[vic_pkg::EVT_W-1:0] = evtStat_r;
                vic_pkg::OFF_EVT_MASK: rdMux[vic_pkg::EVT_W-1:0] = evtMask_r;
                default:               mapped = 1'b0;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regRdData_r <= '0;
        end else begin
            regRdData_r <= regRd ? rdMux : '0;
        end
    end

    // ----------
    // outputs
    // ----------
    assign regRdData   = regRdData_r;
    assign fastLineN   = fastLineN_r;
    assign normalLineN = normalLineN_r;
    assign sysIntr     = sysIntr_r;
endmodule

// file: verilog/vic_pkg.sv
// shared constants and types for the vectored interrupt register file
package vic_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int         NSRC        = 32;
    localparam int         ADDR_W      = 12;
    localparam int         ID_W        = 5;
    localparam int         PRI_W       = 3;
    localparam int         STK_DEPTH   = 8;
    localparam int         EVT_W       = 4;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_MODE_BASE = 12'h000;
    localparam logic [11:0] OFF_VEC_BASE  = 12'h080;
    localparam logic [11:0] OFF_NORM_VEC  = 12'h100;
    localparam logic [11:0] OFF_FAST_VEC  = 12'h104;
    localparam logic [11:0] OFF_CUR_ID    = 12'h108;
    localparam logic [11:0] OFF_PEND      = 12'h10C;
    localparam logic [11:0] OFF_ENABLED   = 12'h110;
    localparam logic [11:0] OFF_CORE      = 12'h114;
    localparam logic [11:0] OFF_EN_CMD    = 12'h120;
    localparam logic [11:0] OFF_DIS_CMD   = 12'h124;
    localparam logic [11:0] OFF_CLR_CMD   = 12'h128;
    localparam logic [11:0] OFF_EOI_CMD   = 12'h130;
    localparam logic [11:0] OFF_EVT_STAT  = 12'h140;
    localparam logic [11:0] OFF_EVT_MASK  = 12'h144;
    // ------------------------------------------------------------
    // source map, field positions, reset values
    // ------------------------------------------------------------
    localparam logic [31:0] IMPL_SRC      = 32'h0007_01FF;
    localparam logic [31:0] EXT_SRC       = 32'h0007_0001;
    localparam int          MODE_PRI_LSB  = 0;
    localparam int          MODE_EDGE_BIT = 5;
    localparam int          MODE_POL_BIT  = 6;
    localparam int          CORE_FAST_BIT = 0;
    localparam int          CORE_NORM_BIT = 1;
    localparam int          EV_FAST       = 0;
    localparam int          EV_NORM       = 1;
    localparam int          EV_BAD_ADDR   = 2;
    localparam int          EV_EOI_EMPTY  = 3;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic             pol;      // 1: active high / rising
        logic             edgeTrig; // 1: edge triggered
        logic [PRI_W-1:0] pri;      // priority level
    } vic_mode_t;
    typedef struct packed {
        logic             valid;
        logic [ID_W-1:0]  id;
        logic [PRI_W-1:0] pri;
    } vic_pick_t;
endpackage

// file: verilog/vic_src_cond.sv
// source conditioning: pin synchroniser, polarity and edge detect
`timescale 1ns/1ps
module vic_src_cond #(
    parameter int          N        = 32,
    parameter logic [31:0] EXT_MASK = 32'h0007_0001
) (
    input  wire logic         ref_clk, // system clock
    input  wire logic         rst,     // sync reset, high
    input  wire logic [N-1:0] srcRaw,  // raw source levels
    input  wire logic [N-1:0] invert,  // per source inversion
    output logic      [N-1:0] actv,    // active level
    output logic      [N-1:0] rise     // became active this cycle
);
    logic [N-1:0] syncA_r;
    logic [N-1:0] syncB_r;
    logic [N-1:0] prev_r;

    // two flops for pin-driven sources
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= srcRaw;
            syncB_r <= syncA_r;
        end
    end

    // pick synced or direct, apply polarity
    always_comb begin
        actv = ((syncB_r & EXT_MASK[N-1:0]) | (srcRaw & ~EXT_MASK[N-1:0])) ^ invert;
        rise = actv & ~prev_r;
    end

    // previous active level for edge detect
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_r <= '0;
        end else begin
            prev_r <= actv;
        end
    end
endmodule

// file: verilog/vic_pick.sv
// highest priority candidate among sources 1 and up
`timescale 1ns/1ps
module vic_pick #(
    parameter int N = 32
) (
    input  wire logic [N-1:0]            cand, // enabled and pending
    input  wire logic [vic_pkg::PRI_W-1:0] prio [N], // per source level
    output vic_pkg::vic_pick_t           best  // winner
);
    // strict compare keeps the lowest number on a tie
    always_comb begin
        best = '0;
        for (int i = 1; i < N; i++) begin
            if (cand[i] && (!best.valid || prio[i] > best.pri)) begin
                best.valid = 1'b1;
                best.id    = vic_pkg::ID_W'(i);
                best.pri   = prio[i];
            end
        end
    end
endmodule

// file: verif/vic_regfile_props.sv
// port-level checks on the vectored interrupt register file
`timescale 1ns/1ps
module vic_regfile_props #(
    parameter int N     = 32,
    parameter int DEPTH = 8
) (
    input wire logic         ref_clk,     // system clock
    input wire logic         rst,         // sync reset, high
    input wire logic [11:0]  regAddr,     // byte address
    input wire logic [31:0]  regWrData,   // write data
    input wire logic         regWr,       // write strobe
    input wire logic         regRd,       // read strobe
    input wire logic [31:0]  regRdData,   // read data
    input wire logic [N-1:0] srcIn,       // interrupt sources
    input wire logic         fastLineN,   // fast request, low
    input wire logic         normalLineN, // normal request, low
    input wire logic         sysIntr      // event interrupt
);
    logic        lastRd; // read strobe one cycle back
    logic [11:0] lastA;  // address one cycle back
    wire logic   rdCore = lastRd && lastA == vic_pkg::OFF_CORE;
    wire logic   rdId   = lastRd && lastA == vic_pkg::OFF_CUR_ID;
    wire logic   rdPend = lastRd && lastA == vic_pkg::OFF_PEND;
    wire logic   rdMask = lastRd && lastA == vic_pkg::OFF_ENABLED;
    wire logic   rdWo   = lastRd && lastA >= vic_pkg::OFF_EN_CMD && lastA <= vic_pkg::OFF_CLR_CMD;
    // ----------
    // read history
    // ----------
    // remembers which register the current data slot answers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lastRd <= 1'b0;
            lastA  <= 12'h000;
        end else begin
            lastRd <= regRd;
            lastA  <= regAddr;
        end
    end
    // ----------
    // assertions
    // ----------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_rd_data_idle: assert property (!lastRd |-> regRdData == 32'h0)
        else $error("idle read data");
    a_core_fast_rd: assert property (rdCore |-> regRdData[0] == !$past(fastLineN))
        else $error("fast status bit");
    a_core_norm_rd: assert property (rdCore |-> regRdData[1] == !$past(normalLineN)
        && regRdData[31:2] == 30'h0)
        else $error("normal status bit");
    a_cur_id_field: assert property (rdId |-> regRdData[31:5] == 27'h0)
        else $error("id upper bits");
    a_pend_map: assert property (rdPend |-> (regRdData & ~vic_pkg::IMPL_SRC) == 32'h0)
        else $error("pending map");
    a_mask_map: assert property (rdMask |-> (regRdData & ~vic_pkg::IMPL_SRC) == 32'h0)
        else $error("enabled map");
    a_wo_read_zero: assert property (rdWo |-> regRdData == 32'h0)
        else $error("command read");
    a_vec_take_drop: assert property (regRd && regAddr == vic_pkg::OFF_NORM_VEC
        && !normalLineN |=> normalLineN)
        else $error("line after take");
    a_disable_quiet: assert property (regWr && regAddr == vic_pkg::OFF_DIS_CMD
        && regWrData == 32'hFFFF_FFFF |=> ##1 (fastLineN && normalLineN))
        else $error("line after disable");
    c_vec_take: cover property (regRd && regAddr == vic_pkg::OFF_NORM_VEC && !normalLineN);
    c_fast_line: cover property (!fastLineN);
    c_sys_intr: cover property (sysIntr);
endmodule

bind vic_regfile vic_regfile_props #(.N(N), .DEPTH(DEPTH)) u_props (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .srcIn(srcIn),
    .fastLineN(fastLineN), .normalLineN(normalLineN), .sysIntr(sysIntr)
);

// file: verif/vic_src_model.sv
// behavioural model of the peripheral and pin interrupt sources
`timescale 1ns/1ps
module vic_src_model (
    input  wire logic        ref_clk, // system clock
    input  wire logic [31:0] srcLvl,  // requested levels, one bit a source
    output logic      [31:0] srcIn    // levels presented to the controller
);
    // ------------------------------------------------------------
    // sources
    // ------------------------------------------------------------
    // peripherals change their request just after a clock edge
    always_ff @(posedge ref_clk) begin
        srcIn <= srcLvl;
    end
endmodule

// file: verif/vic_regfile_tb.sv
// self-checking bench for the vectored interrupt register file
`timescale 1ns/1ps
module vic_regfile_tb;
    localparam logic [31:0] EXT = vic_pkg::EXT_SRC;
    logic        ref_clk;
    logic        rst;
    logic [11:0] regAddr;
    logic [31:0] regWrData;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdData;
    logic [31:0] srcLvl;
    logic [31:0] srcIn;
    logic        fastLineN;
    logic        normalLineN;
    logic        sysIntr;
    int          errCount;
    int          numChecks;
    // ----------
    // clock, design, sources
    // ----------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    vic_regfile #(.N(32), .DEPTH(8)) DUT (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .srcIn(srcIn),
        .fastLineN(fastLineN), .normalLineN(normalLineN), .sysIntr(sysIntr)
    );
    vic_src_model u_src (.ref_clk(ref_clk), .srcLvl(srcLvl), .srcIn(srcIn));
    // ----------
    // tasks
    // ----------
    task automatic finalReport();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                      input logic [31:0] msk = 32'hFFFF_FFFF);
        @(posedge ref_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), regRdData & msk, exp);
    endtask
    // bounded wait for both core lines, then compare
    task automatic lines(input logic f, input logic n);
        int k;
        k = 0;
        while ((fastLineN !== f || normalLineN !== n) && k < 8) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        chk("fastLineN", {31'h0, fastLineN}, {31'h0, f});
        chk("normalLineN", {31'h0, normalLineN}, {31'h0, n});
        if (k == 8) finalReport();
    endtask
    // ----------
    // sequence
    // ----------
    initial begin
        int i;
        rst = 1'b1;
        regAddr = 12'h000;
        regWrData = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        srcLvl = EXT;
        errCount = 0;
        numChecks = 0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        // reset view of vector, id, pending, enabled, core status
        for (i = 0; i < 6; i++) rd(12'h100 + 12'(4 * i), 32'h0);
        // handler table
        for (i = 0; i < 32; i++) wr(12'h080 + 12'(4 * i), 32'hC0DE_0000 + 32'(i));
        for (i = 0; i < 32; i++) rd(12'h080 + 12'(4 * i), 32'hC0DE_0000 + 32'(i));
        rd(12'h104, 32'hC0DE_0000);
        // enable and disable commands
        wr(12'h120, 32'h0000_0130);
        rd(12'h110, 32'h0000_0130);
        wr(12'h120, 32'hFFFF_FFFF);
        rd(12'h110, vic_pkg::IMPL_SRC);
        rd(12'h120, 32'h0);
        wr(12'h124, 32'hFFFF_FEEF);
        rd(12'h110, 32'h0000_0110);
        wr(12'h124, 32'hFFFF_FFFF);
        rd(12'h110, 32'h0);
        // pending view and bit map
        srcLvl <= 32'hFFFF_FFFF;
        rd(12'h10C, 32'h0000_01FE);
        srcLvl <= 32'h0;
        repeat (4) @(posedge ref_clk);
        rd(12'h10C, 32'h0007_0001);
        srcLvl <= EXT;
        // priorities 0 and 7, nesting, end of interrupt
        wr(12'h014, 32'h0000_0007);
        wr(12'h018, 32'h0000_0007);
        wr(12'h120, 32'h0000_0070);
        srcLvl <= EXT | 32'h10;
        lines(1'b1, 1'b0);
        rd(12'h114, 32'h0000_0002);
        rd(12'h100, 32'hC0DE_0004);
        rd(12'h108, 32'h0000_0004);
        lines(1'b1, 1'b1);
        srcLvl <= EXT | 32'h70;
        lines(1'b1, 1'b0);
        rd(12'h100, 32'hC0DE_0005);
        rd(12'h108, 32'h0000_0005);
        lines(1'b1, 1'b1);
        wr(12'h130, 32'h0);
        lines(1'b1, 1'b0);
        rd(12'h100, 32'hC0DE_0005);
        srcLvl <= EXT;
        wr(12'h130, 32'h0);
        wr(12'h130, 32'h0);
        rd(12'h100, 32'h0);
        // edge source latched, then cleared by command
        wr(12'h01C, 32'h0000_0020);
        wr(12'h120, 32'h0000_0080);
        srcLvl <= EXT | 32'h80;
        @(posedge ref_clk);
        srcLvl <= EXT;
        repeat (3) @(posedge ref_clk);
        rd(12'h10C, 32'h0000_0080);
        lines(1'b1, 1'b0);
        wr(12'h128, 32'h0000_0080);
        rd(12'h10C, 32'h0);
        lines(1'b1, 1'b1);
        wr(12'h124, 32'hFFFF_FFFF);
        // fast line, level source survives vector read
        wr(12'h120, 32'h0000_0001);
        srcLvl <= 32'h0007_0000;
        lines(1'b0, 1'b1);
        rd(12'h114, 32'h0000_0001);
        rd(12'h104, 32'hC0DE_0000);
        lines(1'b0, 1'b1);
        srcLvl <= EXT;
        lines(1'b1, 1'b1);
        // source 0 falling edge, cleared by fast vector read
        wr(12'h000, 32'h0000_0020);
        srcLvl <= 32'h0007_0000;
        lines(1'b0, 1'b1);
        rd(12'h104, 32'hC0DE_0000);
        lines(1'b1, 1'b1);
        srcLvl <= EXT;
        wr(12'h124, 32'hFFFF_FFFF);
        // event interrupt: raise, mask, clear
        wr(12'h144, 32'h0);
        wr(12'h140, 32'h0000_000F);
        rd(12'h118, 32'h0);
        rd(12'h140, 32'h0000_0004, 32'h0000_0004);
        chk("sysIntr", {31'h0, sysIntr}, 32'h0);
        wr(12'h144, 32'h0000_0004);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("sysIntr", {31'h0, sysIntr}, 32'h1);
        wr(12'h140, 32'h0000_0004);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("sysIntr", {31'h0, sysIntr}, 32'h0);
        finalReport();
    end
endmodule
